// ===== dct_pkg.sv
// Purpose: Shared constants and types for the DDR command timing block.
// Assumes: Pins sampled by a 100 MHz system clock; APB register access.
// Notes:   Mode fields follow the usual DDR mode register layout.

package dct_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int unsigned DCT_ADDR_W = 13;
  localparam int unsigned DCT_BA_W   = 2;
  localparam int unsigned DCT_DQ_W   = 16;
  localparam int unsigned DCT_COL_W  = 6;
  localparam int unsigned DCT_MEM_AW = 8;
  localparam int unsigned DCT_PAW    = 12;
  localparam int unsigned DCT_PDW    = 32;

  // ==========================================================
  // Register offsets and fields
  // ==========================================================
  localparam logic [11:0] DCT_REG_CTRL   = 12'h000;
  localparam logic [11:0] DCT_REG_STATUS = 12'h004;
  localparam logic [11:0] DCT_REG_MODE   = 12'h008;
  localparam logic [11:0] DCT_REG_WRCNT  = 12'h00C;

  localparam int unsigned DCT_CTRL_EN_BIT  = 0;
  localparam int unsigned DCT_CTRL_CLR_BIT = 1;
  localparam logic        DCT_CTRL_EN_RST  = 1'b1;

  localparam int unsigned DCT_ST_PWR_LSB = 4;
  localparam int unsigned DCT_ST_WR_BIT  = 6;
  localparam int unsigned DCT_ST_RD_BIT  = 7;

  // ==========================================================
  // Mode register layout and codes
  // ==========================================================
  localparam int unsigned DCT_MODE_BL_LSB = 0;
  localparam int unsigned DCT_MODE_BT_BIT = 3;
  localparam int unsigned DCT_MODE_CL_LSB = 4;
  localparam int unsigned DCT_AP_BIT      = 10;
  localparam logic [12:0] DCT_MODE_RST    = 13'h0022;

  localparam logic [2:0] DCT_BL_CODE_2  = 3'h1;
  localparam logic [2:0] DCT_BL_CODE_4  = 3'h2;
  localparam logic [2:0] DCT_BL_CODE_8  = 3'h3;
  localparam logic [2:0] DCT_CL_CODE_2  = 3'h2;
  localparam logic [2:0] DCT_CL_CODE_3  = 3'h3;
  localparam logic [2:0] DCT_CL_CODE_25 = 3'h6;

  // Read latency in link half-periods
  localparam logic [3:0] DCT_HALF_CL2  = 4'h4;
  localparam logic [3:0] DCT_HALF_CL25 = 4'h5;
  localparam logic [3:0] DCT_HALF_CL3  = 4'h6;

  // ==========================================================
  // Commands {ras_n, cas_n, we_n} and power states
  // ==========================================================
  typedef enum logic [2:0] {
    CMD_MRS = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } dct_cmd_t;

  typedef enum logic [1:0] {
    PWR_RUN    = 2'h0,
    PWR_PD_PRE = 2'h1,
    PWR_PD_ACT = 2'h2
  } dct_pwr_t;

endpackage : dct_pkg

// ===== dct_sync.sv
// Purpose: Two-flop synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level from outside i_clk.
// Notes:   Only the second stage may be read by other logic.

`timescale 1ns/1ps

module dct_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      o_q     <= '0;
    end else begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end

endmodule : dct_sync

// ===== dct_mem.sv
// Purpose: Small array with byte-lane write enables and registered read.
// Assumes: One write and one read port on the same clock.
// Notes:   Contents are not reset; read data lag the address by one cycle.

`timescale 1ns/1ps

module dct_mem #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 16
) (
  input  wire logic            i_clk,
  input  wire logic            i_we,
  input  wire logic [AW-1:0]   i_waddr,
  input  wire logic [DW/8-1:0] i_wbe,
  input  wire logic [DW-1:0]   i_wdata,
  input  wire logic [AW-1:0]   i_raddr,
  output logic      [DW-1:0]   o_rdata
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // ==========================================================
  // Byte lanes
  // ==========================================================
  for (genvar b = 0; b < DW/8; b++) begin : g_lane
    always_ff @(posedge i_clk) begin
      if (i_we && i_wbe[b]) begin
        mem_q[i_waddr][8*b +: 8] <= i_wdata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem_q[i_raddr];
  end

endmodule : dct_mem

// ===== dct_top.sv
// Purpose: Command decode, burst timing and power-down of a 4-bank x16
//          DDR memory, seen from inside the device.
// Assumes: Link clock and pins sampled by i_clk; link much slower.
// Notes:   No read preamble; data in are taken on each strobe edge from the first rise of a write burst.
//
// Behaviour
// - New WRITE during a burst truncates it; new burst data follow.
// - Consecutive WRITEs may target any bank.
// - A10 low on WRITE means no automatic precharge after the burst.
// - READ interrupting write keeps only data already supplied.
// - Precharge interrupting a BL4 write makes the strobe ignored.
// - Power-down is precharge type if all idle, else active type.
//
// Decided for this implementation: the address map and the APB slave port.

`timescale 1ns/1ps

module dct_top
  import dct_pkg::*;
(
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [dct_pkg::DCT_PAW-1:0]  i_paddr,
  input  wire logic [dct_pkg::DCT_PDW-1:0]  i_pwdata,
  output logic      [dct_pkg::DCT_PDW-1:0]  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  input  wire logic                         i_ck,
  input  wire logic                         i_cke,
  input  wire logic                         i_cs_n,
  input  wire logic                         i_ras_n,
  input  wire logic                         i_cas_n,
  input  wire logic                         i_we_n,
  input  wire logic [dct_pkg::DCT_BA_W-1:0] i_ba,
  input  wire logic [dct_pkg::DCT_ADDR_W-1:0] i_addr,
  input  wire logic [dct_pkg::DCT_DQ_W-1:0] i_dq,
  output logic      [dct_pkg::DCT_DQ_W-1:0] o_dq,
  output logic                              o_dq_oe,
  input  wire logic                         i_dqs,
  output logic                              o_dqs,
  output logic                              o_dqs_oe,
  input  wire logic                         i_upper_byte_write_mask,
  input  wire logic                         i_lower_byte_write_mask
);

  import dct_pkg::*;

  localparam int unsigned PIN_W = 40;

  // ==========================================================
  // Pin synchronisation and edge detection
  // ==========================================================
  logic [PIN_W-1:0]      pins_s;
  logic                  ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
  logic [DCT_BA_W-1:0]   ba_s;
  logic [DCT_ADDR_W-1:0] addr_s;
  logic [DCT_DQ_W-1:0]   dq_s;
  logic                  dqs_s, umask_s, lmask_s;
  logic                  ck_d_ff, dqs_d_ff, cke_prev_ff;

  dct_sync #(.W(PIN_W)) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({i_ck, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba,
                 i_addr, i_dq, i_dqs, i_upper_byte_write_mask,
                 i_lower_byte_write_mask}),
    .o_q       (pins_s)
  );

  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s,
          dq_s, dqs_s, umask_s, lmask_s} = pins_s;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ck_d_ff  <= 1'b0;
      dqs_d_ff <= 1'b0;
    end else begin
      ck_d_ff  <= ck_s;
      dqs_d_ff <= dqs_s;
    end
  end

  logic ck_rise, ck_edge, dqs_rise, dqs_edge;
  assign ck_rise  = ck_s & ~ck_d_ff;
  assign ck_edge  = ck_s ^ ck_d_ff;
  assign dqs_rise = dqs_s & ~dqs_d_ff;
  assign dqs_edge = dqs_s ^ dqs_d_ff;

  // ==========================================================
  // Command decode
  // ==========================================================
  logic      en_ff;
  dct_pwr_t  pwr_ff;
  dct_cmd_t  cmd;
  logic      cmd_ok;
  logic      is_act, is_pre, is_wr, is_rd, is_bst, is_mrs;

  assign cmd    = dct_cmd_t'({ras_n_s, cas_n_s, we_n_s});
  // Commands only count in run state with the clock enable held high
  assign cmd_ok = ck_rise & ~cs_n_s & cke_s & en_ff & (pwr_ff == PWR_RUN);
  assign is_act = cmd_ok & (cmd == CMD_ACT);
  assign is_pre = cmd_ok & (cmd == CMD_PRE);
  assign is_wr  = cmd_ok & (cmd == CMD_WR);
  assign is_rd  = cmd_ok & (cmd == CMD_RD);
  assign is_bst = cmd_ok & (cmd == CMD_BST);
  assign is_mrs = cmd_ok & (cmd == CMD_MRS) & (ba_s == '0);

  // ==========================================================
  // Mode register
  // ==========================================================
  logic [DCT_ADDR_W-1:0] mode_ff;
  logic [2:0]            bl_mask;
  logic [3:0]            cl_half;
  logic                  il_mode;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      mode_ff <= DCT_MODE_RST;
    end else if (is_mrs) begin
      // Waiting out the mode delay is the controller's job
      mode_ff <= addr_s;
    end
  end

  always_comb begin
    unique case (mode_ff[DCT_MODE_BL_LSB +: 3])
      DCT_BL_CODE_2: bl_mask = 3'h1;
      DCT_BL_CODE_4: bl_mask = 3'h3;
      DCT_BL_CODE_8: bl_mask = 3'h7;
      default:       bl_mask = 3'h3;
    endcase
    unique case (mode_ff[DCT_MODE_CL_LSB +: 3])
      DCT_CL_CODE_25: cl_half = DCT_HALF_CL25;
      DCT_CL_CODE_3:  cl_half = DCT_HALF_CL3;
      default:        cl_half = DCT_HALF_CL2;
    endcase
  end
  assign il_mode = mode_ff[DCT_MODE_BT_BIT];

  function automatic logic [DCT_COL_W-1:0] burst_col(
    input logic [DCT_COL_W-1:0] base,
    input logic [2:0]           idx,
    input logic [2:0]           mask,
    input logic                 il
  );
    logic [2:0] low;
    low = il ? (base[2:0] ^ idx) : 3'(base[2:0] + idx);
    burst_col = {base[DCT_COL_W-1:3], (base[2:0] & ~mask) | (low & mask)};
  endfunction : burst_col

  // ==========================================================
  // Write burst
  // ==========================================================
  logic                 wr_act_ff, wr_seen_ff, wr_ap_ff;
  logic [2:0]           wr_idx_ff;
  logic [DCT_BA_W-1:0]  wr_bank_ff;
  logic [DCT_COL_W-1:0] wr_col_ff;
  logic                 wr_cap, wr_last;

  // Burst starts on a strobe rise; falls before it are preamble
  assign wr_cap  = wr_act_ff & dqs_edge & (dqs_rise | wr_seen_ff);
  assign wr_last = wr_idx_ff == bl_mask;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_act_ff  <= 1'b0;
      wr_seen_ff <= 1'b0;
      wr_ap_ff   <= 1'b0;
      wr_idx_ff  <= '0;
      wr_bank_ff <= '0;
      wr_col_ff  <= '0;
    end else if (is_wr) begin
      wr_act_ff  <= 1'b1;
      wr_seen_ff <= 1'b0;
      wr_idx_ff  <= '0;
      wr_bank_ff <= ba_s;
      wr_col_ff  <= addr_s[DCT_COL_W-1:0];
      wr_ap_ff   <= addr_s[DCT_AP_BIT];
    end else if (is_rd) begin
      wr_act_ff  <= 1'b0;
    end else if (is_pre) begin
      wr_act_ff  <= 1'b0;
    end else if (wr_cap) begin
      wr_seen_ff <= 1'b1;
      wr_idx_ff  <= wr_idx_ff + 3'h1;
      if (wr_last) begin
        wr_act_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read burst
  // ==========================================================
  logic                 rd_pend_ff, rd_ap_ff;
  logic [3:0]           rd_lat_ff;
  logic [2:0]           rd_idx_ff;
  logic [DCT_BA_W-1:0]  rd_bank_ff;
  logic [DCT_COL_W-1:0] rd_col_ff;
  logic                 rd_emit, rd_last;

  assign rd_emit = rd_pend_ff & ck_edge & (rd_lat_ff == 4'h0);
  assign rd_last = rd_idx_ff == bl_mask;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rd_pend_ff <= 1'b0;
      rd_ap_ff   <= 1'b0;
      rd_lat_ff  <= '0;
      rd_idx_ff  <= '0;
      rd_bank_ff <= '0;
      rd_col_ff  <= '0;
    end else if (is_rd) begin
      rd_pend_ff <= 1'b1;
      rd_lat_ff  <= cl_half - 4'h1;
      rd_idx_ff  <= '0;
      rd_bank_ff <= ba_s;
      rd_col_ff  <= addr_s[DCT_COL_W-1:0];
      rd_ap_ff   <= addr_s[DCT_AP_BIT];
    end else if (is_bst) begin
      // Terminate ends the read so a write may follow
      rd_pend_ff <= 1'b0;
    end else if (rd_pend_ff && ck_edge) begin
      // A precharge does not cut data already in flight
      if (rd_lat_ff != 4'h0) begin
        rd_lat_ff <= rd_lat_ff - 4'h1;
      end else begin
        rd_idx_ff <= rd_idx_ff + 3'h1;
        if (rd_last) begin
          rd_pend_ff <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Data array
  // ==========================================================
  logic [DCT_DQ_W-1:0] mem_rdata;

  dct_mem #(.AW(DCT_MEM_AW), .DW(DCT_DQ_W)) u_mem (
    .i_clk   (i_clk),
    .i_we    (wr_cap),
    .i_waddr ({wr_bank_ff,
               burst_col(wr_col_ff, wr_idx_ff, bl_mask, il_mode)}),
    .i_wbe   ({~umask_s, ~lmask_s}),
    .i_wdata (dq_s),
    .i_raddr ({rd_bank_ff,
               burst_col(rd_col_ff, rd_idx_ff, bl_mask, il_mode)}),
    .o_rdata (mem_rdata)
  );

  // Pins are driven for one half-period per element
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_dq     <= '0;
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
    end else if (rd_emit) begin
      o_dq     <= mem_rdata;
      o_dq_oe  <= 1'b1;
      o_dqs    <= ~rd_idx_ff[0];
      o_dqs_oe <= 1'b1;
    end else if (ck_edge) begin
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
    end
  end

  // ==========================================================
  // Bank state
  // ==========================================================
  logic [3:0] open_ff;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      open_ff <= '0;
    end else begin
      if (wr_cap && wr_last && wr_ap_ff) begin
        open_ff[wr_bank_ff] <= 1'b0;
      end
      if (rd_emit && rd_last && rd_ap_ff) begin
        open_ff[rd_bank_ff] <= 1'b0;
      end
      if (is_pre) begin
        if (addr_s[DCT_AP_BIT]) begin
          open_ff <= '0;
        end else begin
          open_ff[ba_s] <= 1'b0;
        end
      end
      if (is_act) begin
        open_ff[ba_s] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Power-down
  // ==========================================================
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cke_prev_ff <= 1'b0;
    end else if (ck_rise) begin
      cke_prev_ff <= cke_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pwr_ff <= PWR_RUN;
    end else if (ck_rise) begin
      unique case (pwr_ff)
        PWR_RUN: begin
          // Column accesses are assumed finished by the controller
          if (cke_prev_ff && !cke_s) begin
            pwr_ff <= (open_ff == '0) ? PWR_PD_PRE : PWR_PD_ACT;
          end
        end
        PWR_PD_PRE, PWR_PD_ACT: begin
          if (cke_s) begin
            pwr_ff <= PWR_RUN;
          end
        end
        default: pwr_ff <= PWR_RUN;
      endcase
    end
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  logic [15:0] wr_cnt_ff;
  logic        apb_acc, apb_wr, apb_hit;

  assign apb_acc = i_psel & i_penable & ~o_pready;
  assign apb_wr  = i_psel & i_penable & o_pready & i_pwrite;
  assign apb_hit = (i_paddr == DCT_REG_CTRL) | (i_paddr == DCT_REG_STATUS) |
                   (i_paddr == DCT_REG_MODE) | (i_paddr == DCT_REG_WRCNT);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      en_ff <= DCT_CTRL_EN_RST;
    end else if (apb_wr && i_paddr == DCT_REG_CTRL) begin
      en_ff <= i_pwdata[DCT_CTRL_EN_BIT];
    end
  end

  // Counts stored data elements; clearing loses a same-cycle count
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_cnt_ff <= '0;
    end else if (apb_wr && i_paddr == DCT_REG_CTRL &&
                 i_pwdata[DCT_CTRL_CLR_BIT]) begin
      wr_cnt_ff <= '0;
    end else if (wr_cap) begin
      wr_cnt_ff <= wr_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      o_pready  <= apb_acc;
      o_pslverr <= apb_acc & ~apb_hit;
      if (apb_acc && !i_pwrite) begin
        unique case (i_paddr)
          DCT_REG_CTRL:   o_prdata <= {31'h0, en_ff};
          DCT_REG_STATUS: o_prdata <= {24'h0, rd_pend_ff, wr_act_ff,
                                       pwr_ff, open_ff};
          DCT_REG_MODE:   o_prdata <= {19'h0, mode_ff};
          DCT_REG_WRCNT:  o_prdata <= {16'h0, wr_cnt_ff};
          default:        o_prdata <= '0;
        endcase
      end
    end
  end

endmodule : dct_top

// ===== dct_top_props.sv
// Purpose: Port-level checks for dct_top.
// Assumes: One clock; link far slower than i_clk.
// Notes:   Bound below.
`timescale 1ns/1ps
module dct_top_props (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] o_prdata,
  input  wire logic        o_pready,
  input  wire logic        o_pslverr,
  input  wire logic        o_dq_oe,
  input  wire logic        o_dqs,
  input  wire logic        o_dqs_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ==========
  // Bus answer
  // ==========
  sequence s_wait;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_hole;
    s_wait ##0 (i_paddr > 12'h00C);
  endsequence
  a_ready_late: assert property (s_wait |=> o_pready)
    else $error("late ready");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("long ready");
  a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("stray ready");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("lone error");
  a_err_hole: assert property (s_hole |=> o_pslverr)
    else $error("hole not refused");
  a_zero_hole: assert property (s_hole ##0 !i_pwrite |=> o_prdata == 32'h0)
    else $error("hole read not 0");
  // ==========
  // Link outputs
  // ==========
  // Strobe must settle for two cycles after each change, else elements get lost
  sequence s_elem;
    $changed(o_dqs) && o_dqs_oe;
  endsequence
  a_quiet_start: assert property ($rose(i_reset_n) |->
      !o_pready && !o_dq_oe && !o_dqs_oe)
    else $error("active after reset");
  a_first_high: assert property ($rose(o_dqs_oe) |-> o_dqs)
    else $error("first strobe low");
  a_elem_hold: assert property (s_elem |=> $stable(o_dqs) [*2])
    else $error("short element");
endmodule : dct_top_props

bind dct_top dct_top_props i_props (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe)
);

// ===== dct_ctl_model.sv
// Purpose: Controller model on the link side.
// Assumes: Free-running 80 ns link clock.
// Notes:   Timing kept by wide gaps, not counters.
`timescale 1ns/1ps
module dct_ctl_model
  import dct_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_dqs,
  input  wire logic        i_dqs_oe,
  output logic             o_ck,
  output logic             o_cke,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic [1:0]       o_ba,
  output logic [12:0]      o_addr,
  output logic [15:0]      o_dq,
  output logic             o_dqs,
  output logic             o_ubm,
  output logic             o_lbm
);
  logic [15:0] rx_q[$];
  logic        seen_oe, seen_dqs;
  // ==========
  // Clock, idle pins, read capture
  // ==========
  initial begin
    o_ck = 1'b0;
    #3;
    forever #40 o_ck = ~o_ck; // Fixed rate
  end
  initial begin
    {o_cke, seen_oe, seen_dqs, o_dqs, o_ubm, o_lbm} = '0;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    {o_ba, o_addr, o_dq} = '0;
  end
  // Each driven strobe change is an element
  always @(posedge i_clk) begin
    if (i_dqs_oe && (!seen_oe || i_dqs !== seen_dqs))
      rx_q.push_back(i_dq);
    seen_oe  <= i_dqs_oe;
    seen_dqs <= i_dqs;
  end
  // ==========
  // Commands
  // ==========
  task automatic cmd(input dct_cmd_t c, input logic [1:0] ba,
                     input logic [12:0] a);
    @(negedge o_ck); // Wide gaps keep row timing
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = {1'b0, c};
    o_ba = ba;
    o_addr = a;
    @(posedge o_ck);
    #20 {o_cs_n, o_ras_n, o_cas_n, o_we_n} = {1'b0, CMD_NOP};
  endtask : cmd
  task automatic mode_set(input logic [12:0] m);
    cmd(CMD_MRS, 2'h0, m);
    repeat (200) @(posedge o_ck); // Mode and lock wait
  endtask : mode_set
  task automatic init(input logic [12:0] m);
    o_cke = 1'b1;
    repeat (2) @(posedge o_ck);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    mode_set(m | 13'h0100);
    cmd(CMD_REF, 2'h0, 13'h0); // Two refreshes, before precharge
    cmd(CMD_REF, 2'h0, 13'h0);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    mode_set(m);
  endtask : init
  task automatic wr(input logic [1:0] ba, input logic [12:0] a,
                    input logic [15:0] base, input int n,
                    input logic [7:0] um = '0, lm = '0);
    cmd(CMD_WR, ba, a);
    #40;
    for (int k = 0; k < n; k++) begin
      o_dq = base + 16'(k);
      o_ubm = um[k];
      o_lbm = lm[k];
      #20 o_dqs = ~o_dqs;
      #20;
    end
    #40 o_dq = ~o_dq; // Gap
  endtask : wr
  task automatic junk(input int n);
    repeat (n) begin
      #20 o_dqs = ~o_dqs; // Strobe runs on after stop
      o_dq = o_dq + 16'h1111;
    end
  endtask : junk
  task automatic rd(input logic [1:0] ba, input logic [12:0] a,
                    input int n);
    rx_q.delete();
    cmd(CMD_RD, ba, a);
    for (int w = 0; w < 400 && rx_q.size() < n; w++)
      @(posedge i_clk);
    repeat (8) @(posedge i_clk);
    cmd(CMD_BST, ba, a); // Read ended before any write
    repeat (2) @(posedge o_ck); // No precharge before BL/2
  endtask : rd
  task automatic cke_set(input logic v);
    @(negedge o_ck);
    o_cke = v; // Only with no burst in flight
    repeat (2) @(posedge o_ck);
  endtask : cke_set
endmodule : dct_ctl_model

// ===== tb_ddr_sdram_command_timing.sv
// Purpose: Self-checking bench for dct_top.
// Assumes: Link clock from the model.
// Notes:   Expected data rebuilt from bases and masks.
`timescale 1ns/1ps
module tb_ddr_sdram_command_timing;
  import dct_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        ck, cke, cs_n, ras_n, cas_n, we_n, ubm, lbm;
  logic [1:0]  ba;
  logic [12:0] addr;
  logic [15:0] dut_dq, ctl_dq, dq_w;
  logic        dq_oe, dut_dqs, ctl_dqs, dqs_oe, dqs_w;
  int          num_errors, total_checks;
  assign dq_w  = dq_oe ? dut_dq : ctl_dq;
  assign dqs_w = dqs_oe ? dut_dqs : ctl_dqs;
  dct_top i_dut (
    .i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ck(ck), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr),
    .i_dq(dq_w), .o_dq(dut_dq), .o_dq_oe(dq_oe), .i_dqs(dqs_w),
    .o_dqs(dut_dqs), .o_dqs_oe(dqs_oe),
    .i_upper_byte_write_mask(ubm), .i_lower_byte_write_mask(lbm));
  dct_ctl_model i_ctl (
    .i_clk(clk), .i_dq(dq_w), .i_dqs(dqs_w), .i_dqs_oe(dqs_oe),
    .o_ck(ck), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr),
    .o_dq(ctl_dq), .o_dqs(ctl_dqs), .o_ubm(ubm), .o_lbm(lbm));
  // ==========
  // Tasks
  // ==========
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic r);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++;
    {q, r} = {prdata, pslverr};
    {psel, penable} <= 2'b0;
  endtask : apb
  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    logic        r;
    apb(1'b0, a, 32'h0, q, r);
    chk(nm, q, e);
  endtask : rchk
  task automatic burst_chk(input logic [15:0] nb, ob, input int sp, n,
                           input logic [7:0] um = '0, lm = '0);
    logic [15:0] o, e;
    chk("count", 32'(i_ctl.rx_q.size()), 32'(n));
    for (int k = 0; k < n; k++) begin
      o = ob + 16'(k);
      e = (k < sp) ? nb + 16'(k) : o;
      if (um[k]) e[15:8] = o[15:8];
      if (lm[k]) e[7:0] = o[7:0];
      chk("burst", 32'(i_ctl.rx_q[k]), 32'(e));
    end
  endtask : burst_chk
  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  // ==========
  // Tests
  // ==========
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500_000;
    num_errors++;
    $display("[ERR] watchdog expected done seen timeout");
    results();
  end
  initial begin
    logic [31:0] q;
    logic        r;
    {psel, penable, pwrite, rst_n, paddr, pwdata} = '0;
    {num_errors, total_checks} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk("ctrl", DCT_REG_CTRL, 32'h1);
    rchk("status", DCT_REG_STATUS, 32'h0);
    rchk("mode", DCT_REG_MODE, 32'h22);
    rchk("wrcnt", DCT_REG_WRCNT, 32'h0);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, q, r);
    chk("wr_err", 32'(r), 32'h1);
    apb(1'b0, 12'h010, 32'h0, q, r);
    chk("rd_err", 32'(r), 32'h1);
    chk("rd_hole", q, 32'h0);
    $display("test registers done");
    i_ctl.init(13'h0022);
    rchk("mode", DCT_REG_MODE, 32'h22);
    i_ctl.cmd(CMD_ACT, 2'h0, '0);
    i_ctl.cmd(CMD_ACT, 2'h1, '0);
    i_ctl.wr(2'h0, '0, 16'hA0A0, 4);
    i_ctl.wr(2'h1, '0, 16'hB0B0, 4);
    rchk("wrcnt", DCT_REG_WRCNT, 32'h8);
    apb(1'b1, DCT_REG_CTRL, 32'h3, q, r);
    rchk("wrcnt_clr", DCT_REG_WRCNT, 32'h0);
    rchk("ctrl", DCT_REG_CTRL, 32'h1);
    i_ctl.wr(2'h0, '0, 16'hC3C3, 4, 8'h2, 8'h4);
    rchk("status", DCT_REG_STATUS, 32'h3);
    i_ctl.rd(2'h0, '0, 4);
    burst_chk(16'hC3C3, 16'hA0A0, 4, 4, 8'h2, 8'h4);
    i_ctl.rd(2'h1, '0, 4);
    burst_chk(16'hB0B0, 16'hB0B0, 4, 4);
    $display("test bl4 writes done");
    i_ctl.wr(2'h0, 13'h4, 16'hD0D0, 4);
    i_ctl.wr(2'h0, 13'h4, 16'hE0E0, 2);
    i_ctl.cmd(CMD_PRE, 2'h0, '0);
    i_ctl.junk(2);
    rchk("status", DCT_REG_STATUS, 32'h2);
    i_ctl.cmd(CMD_ACT, 2'h0, '0);
    i_ctl.rd(2'h0, 13'h4, 4);
    burst_chk(16'hE0E0, 16'hD0D0, 2, 4);
    $display("test strobe stop done");
    i_ctl.cmd(CMD_PRE, 2'h0, 13'h0400);
    i_ctl.cke_set(1'b0);
    rchk("pd_pre", DCT_REG_STATUS, 32'h10);
    i_ctl.cke_set(1'b1);
    i_ctl.cmd(CMD_ACT, 2'h2, '0);
    i_ctl.cke_set(1'b0);
    rchk("pd_act", DCT_REG_STATUS, 32'h24);
    i_ctl.cke_set(1'b1);
    rchk("run", DCT_REG_STATUS, 32'h4);
    $display("test power down done");
    i_ctl.cmd(CMD_PRE, 2'h0, 13'h0400);
    i_ctl.mode_set(13'h0023);
    rchk("mode8", DCT_REG_MODE, 32'h23);
    i_ctl.cmd(CMD_ACT, 2'h2, '0);
    i_ctl.cmd(CMD_ACT, 2'h3, '0);
    i_ctl.wr(2'h2, 13'h10, 16'h5050, 8);
    i_ctl.wr(2'h2, 13'h10, 16'h6060, 2);
    i_ctl.wr(2'h2, 13'h18, 16'h7070, 8);
    i_ctl.rd(2'h2, 13'h10, 8);
    burst_chk(16'h6060, 16'h5050, 2, 8);
    i_ctl.rd(2'h2, 13'h18, 8);
    burst_chk(16'h7070, 16'h7070, 8, 8);
    i_ctl.wr(2'h3, 13'h8, 16'h8080, 8);
    i_ctl.wr(2'h3, 13'h8, 16'h9090, 2);
    i_ctl.rd(2'h3, 13'h8, 8);
    burst_chk(16'h9090, 16'h8080, 2, 8);
    $display("test bl8 writes done");
    results();
  end
endmodule : tb_ddr_sdram_command_timing
